// File: hdl/spi_chan_pkg.sv
// Shared constants and types for the multichannel serial port channel
package spi_chan_pkg;

  // Structure
  localparam int NUM_CHAN   = 8;
  localparam int CHAN_W     = 3;
  localparam int DATA_W     = 128;
  localparam int FIFO_DEPTH = 4;
  localparam int EDGE_W     = 10;

  // Frame length limits, in bits
  localparam logic [7:0] MIN_FRAME_LEN = 8'h02;
  localparam logic [7:0] MAX_FRAME_LEN = 8'h80;

  // Serial clock timing
  localparam longint CLK_HZ  = 100_000_000;
  localparam longint SCLK_HZ = 10_000_000;
  localparam int SCLK_HALF_CYCLES =
    int'((CLK_HZ + 2 * SCLK_HZ - 1) / (2 * SCLK_HZ));

  // Reset values
  localparam logic [7:0] CS_IDLE_LEVEL = 8'hFF;
  localparam logic [7:0] FLAGS_RESET   = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_LOAD  = 2'h1,
    ST_SHIFT = 2'h3,
    ST_DONE  = 2'h2
  } eng_state_t;

  // Per channel setup
  typedef struct packed {
    logic              tx_enable;
    logic              rx_enable;
    logic              cpol;
    logic              cpha;
    logic              lsb_first;
    logic              parity_en;
    logic              consistency_en;
    logic              auto_stop;
    logic [CHAN_W-1:0] cs_index;
    logic [7:0]        frame_length;
    logic [7:0]        frame_count_setting;
  } chan_cfg_t;

  // Sticky error causes
  typedef struct packed {
    logic parity;
    logic consistency;
    logic overwrite;
    logic overread;
    logic overrun;
  } err_t;

endpackage

// File: hdl/multichannel_serial_port_channel.sv
// Transmit FIFO and the multichannel serial port engine

module tx_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  always_comb begin
    push = in_valid & in_ready;
    pop  = out_valid & out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr];
endmodule

// Behaviour
// - Unit runs as serial clock master or as slave.
// - Eight chip select outputs, one chosen per channel.
// - Clock polarity and data phase taken from the transferring channel.
// - Each channel shifts MSB first or LSB first by its setting.
// - Eight transfer channels, each with independent setup.
// - Frame length from 2 to 128 bits in single steps.
// - Internal loopback feeds transmitted data to own receiver.
// - A setting forces all chip selects to idle.
// - Safe protocol variant only active in master operation.
// - Master may sample receive data one clock edge later.
// - Channel moves a programmed count of frames in sequence.
// - Writing transmit data starts the master channel's transfer.
// - Transmit interrupt requests next frame; software then writes it.
// - Receive interrupt after each frame; software reads receive data.
// - Frame-end interrupt after the final frame of the sequence.
// - Three separate pending flag registers for the three events.
// - With auto stop, last frame clears the channel enable.
module multichannel_serial_port_channel #(
  parameter int FIFO_DEPTH = spi_chan_pkg::FIFO_DEPTH,
  parameter int SCLK_HALF  = spi_chan_pkg::SCLK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                                   clk_sys,
  input  wire logic                                   srst,
  // Unit setup
  input  wire logic                                   master_mode,
  input  wire logic                                   internal_loopback,
  input  wire logic                                   force_cs_idle,
  input  wire logic                                   late_sample,
  input  wire logic                                   safe_spi_req,
  output logic                                        safe_spi_active,
  // Channel setup and control
  input  spi_chan_pkg::chan_cfg_t [7:0]               chan_cfg,
  input  wire logic [7:0]                             chan_start,
  input  wire logic [7:0]                             chan_stop,
  output logic      [7:0]                             channel_active_bit,
  // Transmit data
  input  wire logic                                   tx_data_valid,
  input  wire logic [spi_chan_pkg::DATA_W-1:0]        tx_data_reg,
  output logic                                        tx_data_ready,
  // Receive data
  output logic      [spi_chan_pkg::DATA_W-1:0]        rx_data_reg,
  output logic      [spi_chan_pkg::CHAN_W-1:0]        rx_chan,
  output logic                                        rx_data_valid,
  input  wire logic                                   rx_data_read,
  // Event flags and pulses
  output logic      [7:0]                             tx_irq_flag_reg,
  output logic      [7:0]                             rx_irq_flag_reg,
  output logic      [7:0]                             frame_end_flag_reg,
  input  wire logic [7:0]                             tx_flag_clear,
  input  wire logic [7:0]                             rx_flag_clear,
  input  wire logic [7:0]                             frame_end_flag_clear,
  output logic                                        tx_request_irq,
  output logic                                        rx_done_irq,
  output logic                                        frame_end_irq,
  output logic                                        comm_error_irq,
  output spi_chan_pkg::err_t                          error_status,
  input  wire logic                                   error_clear,
  // Serial link
  output logic                                        sclk_out,
  output logic                                        sclk_oe,
  input  wire logic                                   sclk_in,
  output logic                                        serial_data_out,
  input  wire logic                                   serial_data_in,
  output logic      [7:0]                             cs_n_out,
  input  wire logic                                   cs_sel_in_n
);
  localparam int DW = spi_chan_pkg::DATA_W;
  localparam int EW = spi_chan_pkg::EDGE_W;

  function automatic logic [7:0] clamp_len(input logic [7:0] l);
    if (l < spi_chan_pkg::MIN_FRAME_LEN) return spi_chan_pkg::MIN_FRAME_LEN;
    if (l > spi_chan_pkg::MAX_FRAME_LEN) return spi_chan_pkg::MAX_FRAME_LEN;
    return l;
  endfunction

  function automatic logic [DW-1:0] len_mask(input logic [7:0] l);
    return {DW{1'b1}} >> (9'h080 - {1'b0, l});
  endfunction

  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    logic [2:0] r;
    r = '0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction

  // Bit position of serial index within the frame word
  function automatic logic [6:0] bit_pos(input logic [7:0] l,
                                         input logic [7:0] i,
                                         input logic lsb);
    logic [7:0] p;
    p = lsb ? i : 8'(l - 8'h01 - i);
    return p[6:0];
  endfunction

  // Synchronisers
  logic [1:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic [1:0] cs_sync;
  logic       sclk_prev;

  spi_chan_pkg::eng_state_t state, next_state;
  logic [2:0]    cur, next_cur;
  logic [EW-1:0] edge_cnt, next_edge_cnt;
  logic [7:0]    div_cnt, next_div_cnt;
  logic          next_sclk, next_sdo, rx_par, next_rx_par;
  logic [DW-1:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
  logic [DW-1:0] next_rx_data;
  logic [7:0]    frames_left [8];
  logic [7:0]    next_frames_left [8];
  logic [7:0]    next_active, next_cs_n;
  logic [7:0]    tx_set, rx_set, fe_set;
  logic          next_rx_valid;
  logic [2:0]    next_rx_chan;
  spi_chan_pkg::err_t err_ev, next_err;

  // Per cycle decode
  spi_chan_pkg::chan_cfg_t cfg;
  logic [2:0]    ch;
  logic [7:0]    len;
  logic [8:0]    nbits;
  logic [EW-1:0] total, j, idx;
  logic          late_eff, edge_ev, rbit, fifo_valid, fifo_pop;
  logic [DW-1:0] fifo_data, m;

  tx_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (tx_data_valid),
    .in_data   (tx_data_reg),
    .in_ready  (tx_data_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  always_comb begin
    cfg   = chan_cfg[cur];
    len   = clamp_len(cfg.frame_length);
    nbits = {1'b0, len} + {8'h00, cfg.parity_en};
    total = EW'({nbits, 1'b0});
    late_eff = master_mode & late_sample;
    m = len_mask(len);
    next_state = state;
    next_cur = cur;
    next_edge_cnt = edge_cnt;
    next_div_cnt = div_cnt;
    next_sclk = sclk_out;
    next_sdo = serial_data_out;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_rx_par = rx_par;
    next_frames_left = frames_left;
    next_cs_n = cs_n_out;
    next_rx_data = rx_data_reg;
    next_rx_chan = rx_chan;
    next_rx_valid = rx_data_valid;
    tx_set = '0;
    rx_set = '0;
    fe_set = '0;
    err_ev = '0;
    fifo_pop = 1'b0;
    edge_ev = 1'b0;
    j = '0;
    idx = '0;
    rbit = 1'b0;
    ch = lowest_set(channel_active_bit);
    next_active = (channel_active_bit | chan_start) & ~chan_stop;
    for (int i = 0; i < 8; i++) begin
      if (chan_start[i]) begin
        next_frames_left[i] = (chan_cfg[i].frame_count_setting == 8'h00) ?
          8'h01 : chan_cfg[i].frame_count_setting;
        tx_set[i] = chan_cfg[i].tx_enable;
      end
    end
    if (rx_data_read) begin
      if (rx_data_valid) next_rx_valid = 1'b0;
      else err_ev.overread = 1'b1;
    end
    err_ev.overwrite = tx_data_valid & ~tx_data_ready;
    case (state)
      spi_chan_pkg::ST_IDLE: begin
        if (|channel_active_bit && (master_mode || !cs_sync[1]) &&
            (!chan_cfg[ch].tx_enable || fifo_valid)) begin
          next_cur = ch;
          fifo_pop = chan_cfg[ch].tx_enable;
          next_tx_sh = chan_cfg[ch].tx_enable ? fifo_data : '0;
          if (chan_cfg[ch].tx_enable && frames_left[ch] > 8'h01) begin
            tx_set[ch] = 1'b1;
          end
          next_state = spi_chan_pkg::ST_LOAD;
        end
      end
      spi_chan_pkg::ST_LOAD: begin
        if (master_mode) begin
          next_cs_n[cfg.cs_index] = 1'b0;
        end
        next_sclk = cfg.cpol;
        if (!cfg.cpha && cfg.tx_enable) begin
          next_sdo = tx_sh[bit_pos(len, 8'h00, cfg.lsb_first)];
        end
        next_edge_cnt = '0;
        next_div_cnt = '0;
        next_rx_sh = '0;
        next_state = spi_chan_pkg::ST_SHIFT;
      end
      spi_chan_pkg::ST_SHIFT: begin
        if (master_mode) begin
          edge_ev = div_cnt == 8'(SCLK_HALF - 1);
          next_div_cnt = edge_ev ? 8'h00 : div_cnt + 8'h01;
        end else begin
          edge_ev = sclk_sync[1] != sclk_prev;
        end
        if (!master_mode && cs_sync[1]) begin
          next_state = spi_chan_pkg::ST_IDLE;
        end else if (edge_ev) begin
          if (master_mode && edge_cnt < total) begin
            next_sclk = ~sclk_out;
          end
          j = edge_cnt - EW'(late_eff);
          rbit = internal_loopback ? serial_data_out : sdi_sync[1];
          if (edge_cnt >= EW'(late_eff) && j < total &&
              j[0] == cfg.cpha && cfg.rx_enable) begin
            if (j[8:1] == len) next_rx_par = rbit;
            else next_rx_sh[bit_pos(len, j[8:1], cfg.lsb_first)] = rbit;
          end
          idx = (edge_cnt + EW'(1)) >> 1;
          if (edge_cnt[0] != cfg.cpha && idx < EW'(nbits) && cfg.tx_enable) begin
            if (idx[7:0] == len) next_sdo = ~^(tx_sh & m);
            else next_sdo = tx_sh[bit_pos(len, idx[7:0], cfg.lsb_first)];
          end
          if (edge_cnt == total - EW'(1) + EW'(late_eff)) begin
            next_state = spi_chan_pkg::ST_DONE;
          end else begin
            next_edge_cnt = edge_cnt + EW'(1);
          end
        end
      end
      spi_chan_pkg::ST_DONE: begin
        next_cs_n = spi_chan_pkg::CS_IDLE_LEVEL;
        next_frames_left[cur] = frames_left[cur] - 8'h01;
        if (cfg.rx_enable) begin
          err_ev.overrun = next_rx_valid;
          next_rx_data = rx_sh;
          next_rx_chan = cur;
          next_rx_valid = 1'b1;
          rx_set[cur] = 1'b1;
          err_ev.parity = cfg.parity_en & ~(^(rx_sh & m) ^ rx_par);
          err_ev.consistency = cfg.consistency_en & cfg.tx_enable &
                               ((rx_sh & m) != (tx_sh & m));
        end
        if (frames_left[cur] <= 8'h01) begin
          fe_set[cur] = 1'b1;
          if (cfg.auto_stop) begin
            next_active[cur] = 1'b0;
          end else begin
            next_frames_left[cur] = (cfg.frame_count_setting == 8'h00) ?
              8'h01 : cfg.frame_count_setting;
          end
        end
        next_state = spi_chan_pkg::ST_IDLE;
      end
      default: next_state = spi_chan_pkg::ST_IDLE;
    endcase
    if (force_cs_idle || !master_mode) begin
      next_cs_n = spi_chan_pkg::CS_IDLE_LEVEL;
    end
    next_err = (error_status & ~{5{error_clear}}) | err_ev;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclk_sync <= '0;
      sdi_sync <= '0;
      cs_sync <= 2'h3;
      sclk_prev <= 1'b0;
      state <= spi_chan_pkg::ST_IDLE;
      cur <= '0;
      edge_cnt <= '0;
      div_cnt <= '0;
      sclk_out <= 1'b0;
      sclk_oe <= 1'b0;
      serial_data_out <= 1'b0;
      tx_sh <= '0;
      rx_sh <= '0;
      rx_par <= 1'b0;
      frames_left <= '{default: 8'h00};
      channel_active_bit <= 8'h00;
      cs_n_out <= spi_chan_pkg::CS_IDLE_LEVEL;
      rx_data_reg <= '0;
      rx_chan <= '0;
      rx_data_valid <= 1'b0;
      tx_irq_flag_reg <= spi_chan_pkg::FLAGS_RESET;
      rx_irq_flag_reg <= spi_chan_pkg::FLAGS_RESET;
      frame_end_flag_reg <= spi_chan_pkg::FLAGS_RESET;
      tx_request_irq <= 1'b0;
      rx_done_irq <= 1'b0;
      frame_end_irq <= 1'b0;
      comm_error_irq <= 1'b0;
      error_status <= '0;
      safe_spi_active <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk_in};
      sdi_sync <= {sdi_sync[0], serial_data_in};
      cs_sync <= {cs_sync[0], cs_sel_in_n};
      sclk_prev <= sclk_sync[1];
      state <= next_state;
      cur <= next_cur;
      edge_cnt <= next_edge_cnt;
      div_cnt <= next_div_cnt;
      sclk_out <= next_sclk;
      sclk_oe <= master_mode;
      serial_data_out <= next_sdo;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      rx_par <= next_rx_par;
      frames_left <= next_frames_left;
      channel_active_bit <= next_active;
      cs_n_out <= next_cs_n;
      rx_data_reg <= next_rx_data;
      rx_chan <= next_rx_chan;
      rx_data_valid <= next_rx_valid;
      // Hardware set wins over a same-cycle clear
      tx_irq_flag_reg <= (tx_irq_flag_reg & ~tx_flag_clear) | tx_set;
      rx_irq_flag_reg <= (rx_irq_flag_reg & ~rx_flag_clear) | rx_set;
      frame_end_flag_reg <= (frame_end_flag_reg & ~frame_end_flag_clear) |
                            fe_set;
      tx_request_irq <= |tx_set;
      rx_done_irq <= |rx_set;
      frame_end_irq <= |fe_set;
      comm_error_irq <= |err_ev;
      error_status <= next_err;
      safe_spi_active <= safe_spi_req & master_mode;
    end
  end

  // Sclk toggles seen in the current frame
  logic [EW-1:0] toggles;
  always_ff @(posedge clk_sys) begin
    if (srst || state == spi_chan_pkg::ST_LOAD) toggles <= '0;
    else if (sclk_out != next_sclk) toggles <= toggles + EW'(1);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_safe_master_only: assert property (!master_mode |=> !safe_spi_active)
    else $error("safe protocol active outside master operation");
  a_cs_force_idle: assert property (force_cs_idle |=> cs_n_out == 8'hFF)
    else $error("chip select active while forced idle");
  a_cs_single: assert property ((cs_n_out != 8'hFF) |-> $onehot(~cs_n_out))
    else $error("more than one chip select active");
  a_sclk_idle_pol: assert property ((state == spi_chan_pkg::ST_SHIFT &&
      master_mode && edge_cnt == '0 && div_cnt == 8'h00) |-> sclk_out == cfg.cpol)
    else $error("serial clock idle level wrong");
  a_frame_edges: assert property ((state == spi_chan_pkg::ST_DONE &&
      master_mode) |-> toggles == total)
    else $error("serial clock edges do not match frame length");
  a_tx_starts: assert property ((state == spi_chan_pkg::ST_IDLE &&
      fifo_pop) |=> state == spi_chan_pkg::ST_LOAD ##1
      state == spi_chan_pkg::ST_SHIFT)
    else $error("transmit write did not start a frame");
  a_rx_done: assert property ((state == spi_chan_pkg::ST_DONE &&
      cfg.rx_enable) |=> rx_done_irq && rx_data_valid &&
      rx_irq_flag_reg[$past(cur)])
    else $error("receive event missing after frame");
  a_frame_end: assert property ((state == spi_chan_pkg::ST_DONE &&
      frames_left[cur] == 8'h01) |=> frame_end_irq &&
      frame_end_flag_reg[$past(cur)])
    else $error("frame end event missing after last frame");
  a_auto_stop: assert property ((state == spi_chan_pkg::ST_DONE &&
      frames_left[cur] == 8'h01 && cfg.auto_stop && !chan_start[cur]) |=>
      !channel_active_bit[$past(cur)])
    else $error("channel still enabled after last frame");
  a_overrun_err: assert property ((state == spi_chan_pkg::ST_DONE &&
      cfg.rx_enable && rx_data_valid && !rx_data_read) |=>
      comm_error_irq && error_status.overrun)
    else $error("overrun not reported");

  c_frame_end: cover property (frame_end_irq);
  c_slave_frame: cover property (state == spi_chan_pkg::ST_DONE && !master_mode);
  c_loopback: cover property (internal_loopback && rx_done_irq);
  c_late_sample: cover property (late_eff && state == spi_chan_pkg::ST_DONE);
endmodule

// File: test/spi_far_end.sv
// Serial slave stand-in that loops data out back to data in
module spi_far_end (
  // Clock
  input  wire logic       clk_sys,
  // Link from the block
  input  wire logic       serial_data_out,
  input  wire logic [7:0] cs_n_out,
  // Link to the block
  output logic            serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  always @(posedge clk_sys) begin
    last <= serial_data_in;
  end
  // Unselected line shows no stale value
  always @* begin
    serial_data_in = (&cs_n_out) ? ~last : serial_data_out;
  end
endmodule

// File: test/tb_multichannel_serial_port_channel.sv
// Bench for the multichannel serial port channel
module tb_multichannel_serial_port_channel;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, srst = 1'b1, mm = 1'b1, lb = 1'b0, fci = 1'b0;
  logic ls = 1'b1, ssr = 1'b0, ssa, txv = 1'b0, txr, rxv, rxrd = 1'b0;
  logic ec = 1'b0, sclk, sclk_oe, sdo, sdi, tfi, rfi, fei, cei, seen5 = 0;
  spi_chan_pkg::chan_cfg_t [7:0] cfg = '0;
  spi_chan_pkg::err_t err;
  logic [7:0] st = '0, sp = '0, act, txf, rxf, fef, txc = '0, rxc = '0;
  logic [7:0] fec = '0, cs_n;
  logic [127:0] txd = '0, rxd;
  logic [2:0] rxch;
  int n_errors = 0, n_checks = 0;
  logic sck = 1'b0, csi = 1'b1, fci_q = 1'b0, seen_forced = 1'b0;
  int n_tx = 0, n_rx = 0, n_fe = 0, n_ce = 0;
  always #5 clk_sys = ~clk_sys;
  multichannel_serial_port_channel #(.SCLK_HALF(4))
    multichannel_serial_port_channel_i (
    .clk_sys(clk_sys), .srst(srst), .master_mode(mm),
    .internal_loopback(lb), .force_cs_idle(fci), .late_sample(ls),
    .safe_spi_req(ssr), .safe_spi_active(ssa), .chan_cfg(cfg),
    .chan_start(st), .chan_stop(sp), .channel_active_bit(act),
    .tx_data_valid(txv), .tx_data_reg(txd), .tx_data_ready(txr),
    .rx_data_reg(rxd), .rx_chan(rxch), .rx_data_valid(rxv),
    .rx_data_read(rxrd), .tx_irq_flag_reg(txf), .rx_irq_flag_reg(rxf),
    .frame_end_flag_reg(fef), .tx_flag_clear(txc), .rx_flag_clear(rxc),
    .frame_end_flag_clear(fec), .tx_request_irq(tfi), .rx_done_irq(rfi),
    .frame_end_irq(fei), .comm_error_irq(cei), .error_status(err),
    .error_clear(ec), .sclk_out(sclk), .sclk_oe(sclk_oe), .sclk_in(sck),
    .serial_data_out(sdo), .serial_data_in(sdi), .cs_n_out(cs_n),
    .cs_sel_in_n(csi));
  spi_far_end spi_far_end_i (.clk_sys(clk_sys), .serial_data_out(sdo),
    .cs_n_out(cs_n), .serial_data_in(sdi));
  always @(posedge clk_sys) begin
    if (cs_n[5] === 1'b0) seen5 <= 1'b1;
    if (fci_q && cs_n !== 8'hFF) seen_forced <= 1'b1;
    fci_q <= fci;
    n_tx <= n_tx + int'(tfi === 1'b1);
    n_rx <= n_rx + int'(rfi === 1'b1);
    n_fe <= n_fe + int'(fei === 1'b1);
    n_ce <= n_ce + int'(cei === 1'b1);
  end
  task automatic check(input string what, input logic [127:0] exp,
                       input logic [127:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic push(input logic [127:0] d);
    @(negedge clk_sys);
    txv = 1'b1;
    txd = d;
    @(negedge clk_sys);
    txv = 1'b0;
  endtask
  task automatic pull(input logic [127:0] exp);
    int n;
    n = 0;
    while (rxv !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    check("rx_data_reg", exp, rxd);
    rxrd = 1'b1;
    @(negedge clk_sys);
    rxrd = 1'b0;
  endtask
  task automatic start(input int ch);
    @(negedge clk_sys);
    st[ch] = 1'b1;
    @(negedge clk_sys);
    st = '0;
  endtask
  // Slave frame: select, four link clock edges 40 ns apart, deselect
  task automatic slave_frame();
    @(negedge clk_sys);
    csi = 1'b0;
    repeat (8) @(negedge clk_sys);
    repeat (4) begin
      sck = ~sck;
      repeat (4) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
    csi = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    check("cs_n_out", 8'hFF, cs_n);
    check("tx_data_ready", 1'b1, txr);
    check("channel_active_bit", 8'h00, act);
    ssr = 1'b1;
    mm = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("safe_spi_active slave", 1'b0, ssa);
    mm = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("safe_spi_active master", 1'b1, ssa);
    check("sclk_oe", 1'b1, sclk_oe);
    cfg[0] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0,
               8'h20, 8'h04};
    for (int i = 0; i < 4; i++) push({96'h0, 32'hC0DE_0000 + i});
    check("tx_data_ready full", 1'b0, txr);
    push(128'h5);
    check("overwrite", 1'b1, err.overwrite);
    @(negedge clk_sys);
    ec = 1'b1;
    @(negedge clk_sys);
    ec = 1'b0;
    start(0);
    check("tx_irq_flag_reg", 1'b1, txf[0]);
    for (int i = 0; i < 4; i++) pull({96'h0, 32'hC0DE_0000 + i});
    repeat (4) @(negedge clk_sys);
    check("frame_end_flag_reg", 1'b1, fef[0]);
    check("rx_irq_flag_reg", 1'b1, rxf[0]);
    check("channel_active_bit", 1'b0, act[0]);
    check("sclk rest", 1'b0, sclk);
    check("error_status", 5'h00, err);
    check("tx_request_irq pulses", 4, n_tx);
    check("rx_done_irq pulses", 4, n_rx);
    check("frame_end_irq pulses", 1, n_fe);
    check("comm_error_irq pulses", 1, n_ce);
    @(negedge clk_sys);
    txc = 8'hFF;
    rxc = 8'hFF;
    fec = 8'hFF;
    @(negedge clk_sys);
    {txc, rxc, fec} = '0;
    @(negedge clk_sys);
    check("flags cleared", 24'h0, {txf, rxf, fef});
    lb = 1'b1;
    ls = 1'b0;
    cfg[2] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h5,
               8'h02, 8'h01};
    push(128'hFFFF_FFFE);
    start(2);
    pull(128'h2);
    check("rx_chan", 3'h2, rxch);
    check("cs select", 1'b1, seen5);
    check("parity", 1'b0, err.parity);
    check("consistency", 1'b0, err.consistency);
    repeat (4) @(negedge clk_sys);
    check("sclk rest cpol", 1'b1, sclk);
    fci = 1'b1;
    push(128'h1);
    start(2);
    pull(128'h1);
    check("cs forced idle", 1'b0, seen_forced);
    fci = 1'b0;
    @(negedge clk_sys);
    rxrd = 1'b1;
    @(negedge clk_sys);
    rxrd = 1'b0;
    @(negedge clk_sys);
    check("overread", 1'b1, err.overread);
    mm = 1'b0;
    cfg[1] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0,
               8'h02, 8'h02};
    push(128'h1);
    start(1);
    check("sclk_oe slave", 1'b0, sclk_oe);
    slave_frame();
    push(128'h2);
    slave_frame();
    pull(128'h2);
    check("overrun", 1'b1, err.overrun);
    check("frame_end_flag_reg slave", 1'b1, fef[1]);
    tally_and_finish();
  end
endmodule
